// *** hbds_buf.sv ***
`timescale 1ns/1ns
// Small in-order buffer; the head entry is a register and is the output.
module hbds_buf #(
  parameter int WIDTH = hbds_pkg::CHUNK_W,
  parameter int DEPTH = hbds_pkg::BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Storage entries; entry 0 is the head.
  logic [WIDTH-1:0] ent_q [DEPTH];
  // Number of entries held.
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_d;
  // Handshake outcomes in this cycle.
  logic push;
  logic pop;

  // A push needs room; a pop needs a head entry.
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Count and the two flags are registered from the next count.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d < DEPTH);
      out_valid <= (cnt_d != 0);
    end
  end

  // Entries shift toward the head on a pop; a push fills the next free one.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && (i < DEPTH - 1)) begin
        ent_q[i] <= ent_q[i+1];
      end
      if (push && (i == int'(cnt_q) - (pop ? 1 : 0))) begin
        ent_q[i] <= in_data;
      end
    end
  end

  // The head register is the read data.
  assign out_data = ent_q[0];

endmodule

// *** hbds_chipset.sv ***
`timescale 1ns/1ns
// Chipset model: drives its request pins and latches link transfers.
module hbds_chipset (
  input wire logic core_clk,
  input wire logic [hbds_pkg::DATA_W-1:0] data_n_o,
  input wire logic [hbds_pkg::LANES-1:0] lane_inversion_flag_n_o,
  input wire logic [hbds_pkg::LANES-1:0] data_strobe_pos_n_o,
  input wire logic [hbds_pkg::LANES-1:0] data_strobe_neg_n_o,
  input wire logic data_valid_n_o,
  input wire logic fp_error_break_event_n,
  input wire logic data_input_power_ctl_n_o,
  input wire logic data_input_power_ctl_n_oe,
  output logic data_input_power_ctl_n_i,
  output logic deep_sleep_request_n,
  output logic stop_clock_request_n,
  output logic debug_probe_request_n
);
  // Own drive of the shared receiver power pin.
  logic pwr_req_n = 1'b1;
  // When set, a break indication makes the model release stop clock.
  bit auto_wake = 1'b0;
  // Cycles waited before answering a break; zero answers promptly.
  int wake_dly = 0;
  int wake_cnt = 0;
  // Latched transfers, inversion flags above wire levels.
  logic [67:0] rx_q[$];
  // The model yields the pin while the device drives it.
  assign data_input_power_ctl_n_i = data_input_power_ctl_n_oe ?
    data_input_power_ctl_n_o : pwr_req_n;
  // All requests start released.
  initial begin
    deep_sleep_request_n = 1'b1;
    stop_clock_request_n = 1'b1;
    debug_probe_request_n = 1'b1;
  end
  // Changes the request pins just after a core clock edge.
  task set_pins(input logic dp, input logic st, input logic pr,
    input logic pw);
    @(posedge core_clk);
    deep_sleep_request_n <= dp;
    stop_clock_request_n <= st;
    debug_probe_request_n <= pr;
    pwr_req_n <= pw;
  endtask
  // Answers a pending break by releasing stop clock.
  always @(posedge core_clk) begin
    if (auto_wake && !stop_clock_request_n && !fp_error_break_event_n) begin
      wake_cnt <= wake_cnt + 1;
      if (wake_cnt >= wake_dly) stop_clock_request_n <= 1'b1;
    end else begin
      wake_cnt <= 0;
    end
  end
  // Latches a transfer where the lane strobe falls, once lines settle.
  always @(negedge data_strobe_pos_n_o[0]
    or negedge data_strobe_neg_n_o[0]) begin
    #1;
    if (data_valid_n_o === 1'b0) begin
      rx_q.push_back({lane_inversion_flag_n_o, data_n_o});
    end
  end
endmodule

// *** hbds_chk.sv ***
`timescale 1ns/1ns
// Pin timing checks on the top module.
module hbds_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic xfer_clk,
  input wire logic freq_switch_active,
  input wire logic fp_error_unmasked,
  input wire logic break_event,
  input wire logic deep_sleep_request_n,
  input wire logic stop_clock_request_n,
  input wire logic debug_probe_request_n,
  input wire logic data_input_power_ctl_n_o,
  input wire logic data_input_power_ctl_n_oe,
  input wire logic fp_error_break_event_n,
  input wire hbds_pkg::hbds_pwr_t power_state_q,
  input wire logic [hbds_pkg::LANES-1:0] data_strobe_pos_n_o,
  input wire logic [hbds_pkg::LANES-1:0] data_strobe_neg_n_o,
  input wire logic data_valid_n_o
);
  // Stop clock held long enough to cross the synchroniser.
  sequence stop_held_s;
    !stop_clock_request_n [*4];
  endsequence
  // One chunk: strobes alternate, each pair falling twice.
  sequence quad_s;
    (data_strobe_pos_n_o == 4'h0 && data_strobe_neg_n_o == 4'hf) ##1
    (data_strobe_pos_n_o == 4'hf && data_strobe_neg_n_o == 4'h0) ##1
    (data_strobe_pos_n_o == 4'h0 && data_strobe_neg_n_o == 4'hf) ##1
    (data_strobe_pos_n_o == 4'hf && data_strobe_neg_n_o == 4'h0);
  endsequence
  pwr_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
    freq_switch_active |=> data_input_power_ctl_n_oe
    && !data_input_power_ctl_n_o) else $error("power pin not driven");
  fp_err_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stop_clock_request_n [*5] |-> fp_error_break_event_n
    == !$past(fp_error_unmasked)) else $error("fp error pin wrong");
  brk_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stop_held_s ##0 break_event |-> ##[1:2] !fp_error_break_event_n)
    else $error("break not shown");
  probe_brk_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!stop_clock_request_n && !debug_probe_request_n) [*4]
    |-> ##[0:2] !fp_error_break_event_n) else $error("probe break missing");
  brk_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    stop_held_s ##0 !fp_error_break_event_n |=> !fp_error_break_event_n)
    else $error("break dropped early");
  deep_in_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (power_state_q == hbds_pkg::HBDS_SLEEP && !deep_sleep_request_n) [*3]
    |=> power_state_q == hbds_pkg::HBDS_DEEP_SLEEP) else $error("no deep");
  deep_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (power_state_q == hbds_pkg::HBDS_DEEP_SLEEP && deep_sleep_request_n) [*3]
    |=> power_state_q == hbds_pkg::HBDS_SLEEP) else $error("no wake");
  quad_a: assert property (@(posedge xfer_clk) disable iff (!rstn)
    $fell(data_valid_n_o) |-> quad_s and (!data_valid_n_o [*4]))
    else $error("chunk framing wrong");
endmodule

// *** hbds_pkg.sv ***
package hbds_pkg;

  // Width of one data lane and the number of lanes on the bus.
  localparam int LANE_W = 16;
  localparam int LANES = 4;
  // Full data bus width.
  localparam int DATA_W = LANE_W * LANES;
  // Transfers in one common clock period.
  localparam int PHASES = 4;
  // One chunk holds all transfers of one common clock period.
  localparam int CHUNK_W = DATA_W * PHASES;
  // Depth of the buffer in the transmit path.
  localparam int BUF_DEPTH = 2;
  // A lane is inverted when more bits than this would change.
  localparam int INV_LIMIT = LANE_W / 2;
  // Idle level of every active-low pin.
  localparam logic PIN_IDLE = 1'b1;
  // Level of an asserted active-low pin.
  localparam logic PIN_ASSERT = 1'b0;
  // Reset value of the wire history used for inversion.
  localparam logic [DATA_W-1:0] WIRE_RESET = {DATA_W{1'b1}};

  // Power states seen by this block.
  typedef enum logic [1:0] {
    HBDS_NORMAL,
    HBDS_SLEEP,
    HBDS_DEEP_SLEEP
  } hbds_pwr_t;

endpackage

// *** hbds_top.sv ***
`timescale 1ns/1ns
// Device-side data transmit, sleep-depth and error/break pin logic.
module hbds_top (
  input wire logic core_clk,
  input wire logic rstn,
  // Clock of the link logic, one edge per data transfer.
  input wire logic xfer_clk,
  // Chunk of four transfers from the core.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [hbds_pkg::CHUNK_W-1:0] tx_data,
  // Core has entered its sleep request.
  input wire logic core_sleep_req,
  // Core is changing bus frequency.
  input wire logic freq_switch_active,
  // Core sees an unmasked floating-point error.
  input wire logic fp_error_unmasked,
  // Core break event, one-cycle pulse.
  input wire logic break_event,
  input wire logic deep_sleep_request_n,
  input wire logic stop_clock_request_n,
  input wire logic debug_probe_request_n,
  input wire logic data_input_power_ctl_n_i,
  output logic data_input_power_ctl_n_o,
  output logic data_input_power_ctl_n_oe,
  output logic fp_error_break_event_n,
  // Current power state.
  output hbds_pkg::hbds_pwr_t power_state_q,
  // Receivers may be powered down at the chipset's request.
  output logic rx_power_down_q,
  // Link side pins, all on xfer_clk.
  output logic [hbds_pkg::DATA_W-1:0] data_n_o,
  output logic data_n_oe,
  output logic [hbds_pkg::LANES-1:0] lane_inversion_flag_n_o,
  output logic lane_inversion_flag_n_oe,
  output logic [hbds_pkg::LANES-1:0] data_strobe_pos_n_o,
  output logic [hbds_pkg::LANES-1:0] data_strobe_neg_n_o,
  output logic data_strobe_oe,
  output logic data_valid_n_o,
  output logic data_valid_n_oe
);

  // Counts bits that differ between two lane values.
  function automatic logic [4:0] hbds_diff_cnt(
    input logic [hbds_pkg::LANE_W-1:0] a,
    input logic [hbds_pkg::LANE_W-1:0] b
  );
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < hbds_pkg::LANE_W; i++) begin
      n = n + {4'h0, a[i] ^ b[i]};
    end
    return n;
  endfunction

  // ---------------- Core domain: pin synchronisers ----------------

  // Two-stage synchronisers for the four async input pins.
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  // Synchronised assertions, high when the pin is low.
  logic deep_req;
  logic stop_req;
  logic probe_req;
  logic pwr_req;

  // Pins pass two flip-flops before any logic sees them.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_q <= {4{hbds_pkg::PIN_IDLE}};
      pin_s2_q <= {4{hbds_pkg::PIN_IDLE}};
    end else begin
      pin_s1_q <= {data_input_power_ctl_n_i, debug_probe_request_n,
                   stop_clock_request_n, deep_sleep_request_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pins are asserted at logic zero.
  always_comb begin
    deep_req = (pin_s2_q[0] == hbds_pkg::PIN_ASSERT);
    stop_req = (pin_s2_q[1] == hbds_pkg::PIN_ASSERT);
    probe_req = (pin_s2_q[2] == hbds_pkg::PIN_ASSERT);
    pwr_req = (pin_s2_q[3] == hbds_pkg::PIN_ASSERT);
  end

  // ---------------- Core domain: sleep depth ----------------

  // Next power state.
  hbds_pkg::hbds_pwr_t power_state_d;

  // Sleep depth follows the core request and the chipset pin.
  always_comb begin
    power_state_d = power_state_q;
    case (power_state_q)
      hbds_pkg::HBDS_NORMAL: begin
        // The core enters Sleep on its own request.
        if (core_sleep_req) begin
          power_state_d = hbds_pkg::HBDS_SLEEP;
        end
      end
      hbds_pkg::HBDS_SLEEP: begin
        // Deep sleep request takes priority over leaving Sleep.
        if (deep_req) begin
          power_state_d = hbds_pkg::HBDS_DEEP_SLEEP;
        end else if (!core_sleep_req) begin
          power_state_d = hbds_pkg::HBDS_NORMAL;
        end
      end
      hbds_pkg::HBDS_DEEP_SLEEP: begin
        // Only release of the request leaves Deep Sleep.
        if (!deep_req) begin
          power_state_d = hbds_pkg::HBDS_SLEEP;
        end
      end
      default: begin
        power_state_d = hbds_pkg::HBDS_NORMAL;
      end
    endcase
  end

  // Power state register.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      power_state_q <= hbds_pkg::HBDS_NORMAL;
    end else begin
      power_state_q <= power_state_d;
    end
  end

  // ---------------- Core domain: receiver power pin ----------------

  // The device takes the pin only while the frequency is switching;
  // otherwise the chipset owns it and may power receivers down.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      data_input_power_ctl_n_oe <= 1'b0;
      data_input_power_ctl_n_o <= hbds_pkg::PIN_IDLE;
      rx_power_down_q <= 1'b0;
    end else begin
      data_input_power_ctl_n_oe <= freq_switch_active;
      // Receivers stay powered while the device drives the pin.
      data_input_power_ctl_n_o <= hbds_pkg::PIN_ASSERT;
      rx_power_down_q <= !freq_switch_active && pwr_req;
    end
  end

  // ---------------- Core domain: error and break pin ----------------

  // Sticky pending break event, meaningful only under stop clock.
  logic pbe_q;

  // Break events are caught under stop clock and held until it ends;
  // set and clear never meet because they need opposite stop levels.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pbe_q <= 1'b0;
    end else if (!stop_req) begin
      pbe_q <= 1'b0;
    end else if (break_event || probe_req) begin
      pbe_q <= 1'b1;
    end
  end

  // The shared pin shows the error or the break event by stop clock.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fp_error_break_event_n <= hbds_pkg::PIN_IDLE;
    end else if (stop_req) begin
      // A controller seeing this returns the device to Normal.
      fp_error_break_event_n <= !(pbe_q || break_event || probe_req);
    end else begin
      fp_error_break_event_n <= !fp_error_unmasked;
    end
  end

  // ---------------- Core domain: transmit buffer and crossing ----------------

  // Buffer head and handshake.
  logic buf_valid;
  logic buf_ready;
  logic [hbds_pkg::CHUNK_W-1:0] buf_data;
  // Chunk held stable for the link side while a crossing is open.
  logic [hbds_pkg::CHUNK_W-1:0] hold_q;
  // Request toggle and synchronised acknowledge toggle.
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic xing_busy;

  // Two-entry buffer; a stall of the link fills it and drops tx_ready.
  hbds_buf #(
    .WIDTH(hbds_pkg::CHUNK_W),
    .DEPTH(hbds_pkg::BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // A crossing is open while the acknowledge lags the request.
  always_comb begin
    xing_busy = (req_q != ack_s2_q);
    buf_ready = !xing_busy;
  end

  // Loads a chunk into the hold register and toggles the request.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (buf_valid && buf_ready) begin
      req_q <= !req_q;
      hold_q <= buf_data;
    end
  end

  // Brings the acknowledge toggle back from the link side.
  logic ack_q;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ---------------- Link domain ----------------

  // Reset and request toggle brought into the link clock.
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  // Transfer state: busy flag, phase, and the chunk being sent.
  logic lbusy_q;
  logic [1:0] phase_q;
  logic [hbds_pkg::CHUNK_W-1:0] chunk_q;
  // Last levels driven on the data wires.
  logic [hbds_pkg::DATA_W-1:0] wire_q;
  // Next-edge values.
  logic pend;
  logic take;
  logic lbusy_d;
  logic [1:0] phase_d;
  // Chunk that the next transfer is cut from.
  logic [hbds_pkg::CHUNK_W-1:0] src;
  logic [hbds_pkg::DATA_W-1:0] word;
  logic [hbds_pkg::DATA_W-1:0] wire_d;
  logic [hbds_pkg::LANES-1:0] inv_d;

  // Reset and request synchronisers on the link clock.
  always_ff @(posedge xfer_clk) begin
    lrst_s1_q <= rstn;
    lrst_s2_q <= lrst_s1_q;
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
  end

  // Picks the next transfer and decides lane inversion.
  always_comb begin
    pend = (req_s2_q != ack_q);
    // A new chunk starts at once from idle, else only at a common clock boundary.
    take = pend && (!lbusy_q || (phase_q == 2'(hbds_pkg::PHASES - 1)));
    lbusy_d = take || (lbusy_q && (phase_q != 2'(hbds_pkg::PHASES - 1)));
    phase_d = take ? 2'h0 : phase_q + 2'h1;
    // A newly taken chunk is read straight from the hold register.
    src = take ? hold_q : chunk_q;
    word = src[int'(phase_d) * hbds_pkg::DATA_W +: hbds_pkg::DATA_W];
    wire_d = wire_q;
    inv_d = '0;
    for (int l = 0; l < hbds_pkg::LANES; l++) begin
      // A true bit is a low wire; inversion sends it as a high wire.
      if (int'(hbds_diff_cnt(~word[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W],
          wire_q[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W])) >
          hbds_pkg::INV_LIMIT) begin
        inv_d[l] = 1'b1;
        wire_d[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W] =
          word[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W];
      end else begin
        wire_d[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W] =
          ~word[l*hbds_pkg::LANE_W +: hbds_pkg::LANE_W];
      end
    end
  end

  // Transfer sequencing and acknowledge of a taken chunk.
  always_ff @(posedge xfer_clk) begin
    if (!lrst_s2_q) begin
      lbusy_q <= 1'b0;
      phase_q <= 2'h0;
      chunk_q <= '0;
      ack_q <= 1'b0;
    end else begin
      lbusy_q <= lbusy_d;
      phase_q <= phase_d;
      if (take) begin
        chunk_q <= hold_q;
        ack_q <= req_s2_q;
      end
    end
  end

  // Drives data, inversion flags, strobes and data valid per transfer.
  always_ff @(posedge xfer_clk) begin
    if (!lrst_s2_q) begin
      wire_q <= hbds_pkg::WIRE_RESET;
      data_n_o <= hbds_pkg::WIRE_RESET;
      data_n_oe <= 1'b0;
      lane_inversion_flag_n_o <= {hbds_pkg::LANES{hbds_pkg::PIN_IDLE}};
      lane_inversion_flag_n_oe <= 1'b0;
      data_strobe_pos_n_o <= {hbds_pkg::LANES{hbds_pkg::PIN_IDLE}};
      data_strobe_neg_n_o <= {hbds_pkg::LANES{hbds_pkg::PIN_IDLE}};
      data_strobe_oe <= 1'b0;
      data_valid_n_o <= hbds_pkg::PIN_IDLE;
      data_valid_n_oe <= 1'b0;
    end else if (lbusy_d) begin
      wire_q <= wire_d;
      data_n_o <= wire_d;
      data_n_oe <= 1'b1;
      lane_inversion_flag_n_o <= ~inv_d;
      lane_inversion_flag_n_oe <= 1'b1;
      // Positive strobes fall on even transfers, negative on odd.
      data_strobe_pos_n_o <= {hbds_pkg::LANES{phase_d[0]}};
      data_strobe_neg_n_o <= {hbds_pkg::LANES{!phase_d[0]}};
      data_strobe_oe <= 1'b1;
      data_valid_n_o <= hbds_pkg::PIN_ASSERT;
      data_valid_n_oe <= 1'b1;
    end else begin
      // No chunk ready: an idle clock with the bus released.
      data_n_oe <= 1'b0;
      lane_inversion_flag_n_oe <= 1'b0;
      data_strobe_pos_n_o <= {hbds_pkg::LANES{hbds_pkg::PIN_IDLE}};
      data_strobe_neg_n_o <= {hbds_pkg::LANES{hbds_pkg::PIN_IDLE}};
      data_strobe_oe <= 1'b0;
      data_valid_n_o <= hbds_pkg::PIN_IDLE;
      data_valid_n_oe <= 1'b0;
    end
  end

endmodule

// *** tb_host_bus_data_sleep_signals.sv ***
`timescale 1ns/1ns
// Attaches the pin checker to the top module.
bind hbds_top hbds_chk chk (.*);
// Self-checking bench for the data, sleep and error/break pins.
module tb_host_bus_data_sleep_signals;
  logic core_clk = 1'b0;
  logic xfer_clk = 1'b0;
  logic rstn = 1'b0;
  logic tx_valid = 1'b0;
  logic [hbds_pkg::CHUNK_W-1:0] tx_data = '0;
  logic core_sleep_req = 1'b0;
  logic freq_switch_active = 1'b0;
  logic fp_error_unmasked = 1'b0;
  logic break_event = 1'b0;
  logic tx_ready, rx_power_down_q, fp_error_break_event_n;
  logic deep_sleep_request_n, stop_clock_request_n, debug_probe_request_n;
  logic data_input_power_ctl_n_i, data_input_power_ctl_n_o;
  logic data_input_power_ctl_n_oe, data_n_oe, data_valid_n_o;
  logic lane_inversion_flag_n_oe, data_strobe_oe, data_valid_n_oe;
  hbds_pkg::hbds_pwr_t power_state_q;
  logic [hbds_pkg::DATA_W-1:0] data_n_o;
  logic [hbds_pkg::LANES-1:0] lane_inversion_flag_n_o;
  logic [hbds_pkg::LANES-1:0] data_strobe_pos_n_o, data_strobe_neg_n_o;
  int n_errors = 0;
  int cmp_count = 0;
  // Last wire levels driven, for the lane inversion decision.
  logic [hbds_pkg::DATA_W-1:0] hist = hbds_pkg::WIRE_RESET;
  logic [67:0] exp_q[$];
  hbds_top dut (.*);
  hbds_chipset chip (.*);
  // The link clock rises on core clock falling edges; it runs at 80 ns.
  always #4 core_clk = ~core_clk;
  always #40 xfer_clk = ~xfer_clk;
  task results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t bit %b, expected %b", $time, g, e);
    end
  endtask
  task chk_st(input hbds_pkg::hbds_pwr_t g, input hbds_pkg::hbds_pwr_t e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t power state %0d, expected %0d", $time, g, e);
    end
  endtask
  task chk_xfer(input logic [67:0] g, input logic [67:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t transfer %h, expected %h", $time, g, e);
    end
  endtask
  // Waits a bounded time for the error/break pin to reach v.
  task wait_fp(input logic v, input int n);
    int i;
    for (i = 0; i < n && fp_error_break_event_n !== v; i++) @(posedge core_clk);
    chk_bit(fp_error_break_event_n, v);
    if (i == n) results();
  endtask
  // Wire levels and flags a lane encoder must give for data d.
  function automatic logic [67:0] exp_xfer(input logic [63:0] d);
    logic [3:0] f;
    logic [15:0] w;
    f = 4'hf;
    for (int l = 0; l < 4; l++) begin
      w = ~d[16*l+:16];
      if ($countones(w ^ hist[16*l+:16]) > hbds_pkg::INV_LIMIT) begin
        w = d[16*l+:16];
        f[l] = 1'b0;
      end
      hist[16*l+:16] = w;
    end
    return {f, hist};
  endfunction
  task t_reset();
    repeat (40) @(posedge core_clk);
    chk_bit(tx_ready, 1'b1);
    chk_st(power_state_q, hbds_pkg::HBDS_NORMAL);
    chk_bit(fp_error_break_event_n, 1'b1);
    chk_bit(data_input_power_ctl_n_oe, 1'b0);
    chk_bit(data_valid_n_o, 1'b1);
    chk_bit(data_n_oe, 1'b0);
    chk_bit(data_valid_n_oe, 1'b0);
    chk_bit(data_strobe_oe, 1'b0);
    chk_bit(lane_inversion_flag_n_oe, 1'b0);
    $display("t_reset done");
  endtask
  // Five chunks back to back fill the buffer; words 8 and 15 toggles
  // sit either side of the inversion limit.
  task t_stream();
    logic [255:0] d;
    bit full;
    int i;
    full = 1'b0;
    for (int k = 0; k < 5; k++) begin
      d = {64'h0123_4567_89ab_cdef, {4{16'hff80}}, {4{16'h00ff}}, 64'h0};
      d = d ^ {64{4'(k)}};
      for (int j = 0; j < 4; j++) exp_q.push_back(exp_xfer(d[64*j+:64]));
      tx_data <= d;
      tx_valid <= 1'b1;
      i = 0;
      do begin
        @(posedge core_clk);
        i++;
        if (tx_ready !== 1'b1) full = 1'b1;
      end while (tx_ready !== 1'b1 && i < 200);
      // A buffer that never drains is a hang.
      if (tx_ready !== 1'b1) begin
        chk_bit(tx_ready, 1'b1);
        results();
      end
    end
    tx_valid <= 1'b0;
    chk_bit(full, 1'b1);
    for (i = 0; i < 3000 && chip.rx_q.size() < 20; i++) @(posedge core_clk);
    chk_bit(chip.rx_q.size() == 20, 1'b1);
    if (i == 3000) results();
    while (exp_q.size() > 0) begin
      chk_xfer(chip.rx_q.pop_front(), exp_q.pop_front());
    end
    $display("t_stream done");
  endtask
  task t_sleep();
    core_sleep_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_st(power_state_q, hbds_pkg::HBDS_SLEEP);
    chip.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    chk_st(power_state_q, hbds_pkg::HBDS_DEEP_SLEEP);
    chip.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    chk_st(power_state_q, hbds_pkg::HBDS_SLEEP);
    core_sleep_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_st(power_state_q, hbds_pkg::HBDS_NORMAL);
    $display("t_sleep done");
  endtask
  task t_err();
    fp_error_unmasked <= 1'b1;
    wait_fp(1'b0, 8);
    fp_error_unmasked <= 1'b0;
    wait_fp(1'b1, 8);
    chip.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge core_clk);
    fp_error_unmasked <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_bit(fp_error_break_event_n, 1'b1);
    fp_error_unmasked <= 1'b0;
    break_event <= 1'b1;
    @(posedge core_clk);
    break_event <= 1'b0;
    wait_fp(1'b0, 4);
    repeat (20) @(posedge core_clk);
    chk_bit(fp_error_break_event_n, 1'b0);
    chip.auto_wake = 1'b1;
    wait_fp(1'b1, 8);
    chip.wake_dly = 30;
    chip.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge core_clk);
    chk_bit(fp_error_break_event_n, 1'b0);
    wait_fp(1'b1, 60);
    chip.auto_wake = 1'b0;
    chip.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    $display("t_err done");
  endtask
  task t_pwr();
    chip.set_pins(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (5) @(posedge core_clk);
    chk_bit(rx_power_down_q, 1'b1);
    freq_switch_active <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk_bit(data_input_power_ctl_n_oe, 1'b1);
    chk_bit(data_input_power_ctl_n_i, 1'b0);
    chk_bit(rx_power_down_q, 1'b0);
    freq_switch_active <= 1'b0;
    chip.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    $display("t_pwr done");
  endtask
  // Reset spans four link clock edges so the link side resets too.
  initial begin
    repeat (44) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_stream();
    t_sleep();
    t_err();
    t_pwr();
    results();
  end
  // Cuts a hang short.
  initial begin
    #400000;
    n_errors++;
    $display("ERROR %0t run time limit reached", $time);
    results();
  end
endmodule
